// ---- logic/csu_compare_subtract_unit.v ----
// Purpose: Compare slice of the core ALU with an AXI4-Lite status and control port.
// Assumes: Decoder inputs are on ref_clk; one instruction per 4-clock slot.
// Notes:   Flags and write-back are committed together at the end of the slot.
// Contract
// - Unsigned compare: equal flag on equality, borrow when destination below source.
// - Unsigned compare is code 100001, no write by default, 4 clocks.
// - Signed compare is code 110000, effects 000i, condition 1111, 4 clocks.
// - Signed compare uses two's complement; borrow when destination signed-less.
// - Each flag updates only when its write effect is encoded.
// - Pure compares write the wrapped difference only with result-write.
// - Signed flags follow true order despite overflow; no overflow flag.
// - First operand from destination; second from source or 9-bit immediate.
// - Compare-and-subtract is code 111000, effects 001i, writes, 4 clocks.
// - Compare-and-subtract subtracts when source not above destination, else keeps.
// - Compare-and-subtract carry set when the subtraction was performed.
// - Compare-and-subtract zero set when destination equals source.
// - Compare-and-subtract writes unless suppressed; then only flags change.
// - Signed extended compare is code 110001, effects 000i, 4 clocks.
// - Extended zero is prior zero AND equality with source plus carry.
// - Extended carry set when destination signed-less than source plus carry.
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "csu_defs.vh"

module csu_compare_subtract_unit #(
  parameter [2:0] SLOT_CLOCKS = `CSU_SLOT_CLOCKS
) (
  input  wire                       ref_clk,
  input  wire                       nrst,
  input  wire                       issue_valid,
  output wire                       issue_ready,
  input  wire [5:0]                 instr_code,
  input  wire                       write_equal_flag_effect,
  input  wire                       write_borrow_flag_effect,
  input  wire                       write_result_effect,
  input  wire                       imm_effect,
  input  wire [3:0]                 cond_field,
  input  wire [31:0]                dest_value,
  input  wire [31:0]                src_value,
  input  wire [`CSU_IMM_WIDTH-1:0]  imm_literal,
  input  wire                       zero_in,
  input  wire                       carry_in,
  output reg                        done,
  output reg                        zero_out,
  output reg                        carry_out,
  output reg                        wb_en,
  output reg  [31:0]                wb_data,
  input  wire [`CSU_ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire                       s_axi_awvalid,
  output wire                       s_axi_awready,
  input  wire [31:0]                s_axi_wdata,
  input  wire [3:0]                 s_axi_wstrb,
  input  wire                       s_axi_wvalid,
  output wire                       s_axi_wready,
  output reg  [1:0]                 s_axi_bresp,
  output reg                        s_axi_bvalid,
  input  wire                       s_axi_bready,
  input  wire [`CSU_ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire                       s_axi_arvalid,
  output wire                       s_axi_arready,
  output reg  [31:0]                s_axi_rdata,
  output reg  [1:0]                 s_axi_rresp,
  output reg                        s_axi_rvalid,
  input  wire                       s_axi_rready
);

  localparam [2:0] COMMIT_CNT = SLOT_CLOCKS - 3'h2;

  // Returns high when the byte address names a register of this block.
  function reg_mapped;
    input [`CSU_ADDR_WIDTH-1:0] addr;
    begin
      case (addr)
        `CSU_REG_CTRL, `CSU_REG_STATUS, `CSU_REG_RESULT,
        `CSU_REG_COUNT, `CSU_REG_FLAGS, `CSU_REG_LASTOP:
          reg_mapped = 1'b1;
        default:
          reg_mapped = 1'b0;
      endcase
    end
  endfunction

  // Condition field selects which combinations of carry and zero allow execution.
  function cond_met;
    input [3:0] cond;
    input       c;
    input       z;
    begin
      cond_met = cond[{c, z}];
    end
  endfunction

  reg  [31:0] ctrl_reg;
  reg         busy_reg;
  reg  [2:0]  cnt_reg;
  reg  [1:0]  kind_reg;
  reg         exec_reg;
  reg         unsup_reg;
  reg         zero_wen_reg;
  reg         carry_wen_reg;
  reg         wr_reg;
  reg  [31:0] d_reg;
  reg  [31:0] s_reg;
  reg         z_reg;
  reg         c_reg;
  reg         last_unsup_reg;
  reg         last_skip_reg;
  reg  [31:0] result_reg;
  reg  [31:0] count_reg;
  reg  [5:0]  lastop_reg;
  reg  [1:0]  kind_next;
  reg         known_next;
  reg         zero_next;
  reg         carry_next;
  reg  [31:0] res_next;
  reg         wb_next;
  reg  [31:0] rdata_next;
  wire        take;
  wire        commit;
  wire [31:0] second_operand;
  wire        suppress_result_effect;
  wire [31:0] diff;
  wire        ubor;
  wire        slt;
  wire        eq;
  wire        wr_take;

  assign issue_ready = ~busy_reg & ctrl_reg[`CSU_CTRL_ENABLE];
  assign take        = issue_valid & issue_ready;
  assign commit      = busy_reg & (cnt_reg == COMMIT_CNT);

  assign second_operand = imm_effect ? {`CSU_IMM_PAD, imm_literal} : src_value;

  always @*
  begin
    kind_next  = `CSU_KIND_UCOMP;
    known_next = 1'b1;
    case (instr_code)
      `CSU_OP_UCOMP:    kind_next = `CSU_KIND_UCOMP;
      `CSU_OP_SCOMP:    kind_next = `CSU_KIND_SCOMP;
      `CSU_OP_SCOMP_X:  kind_next = `CSU_KIND_SCOMP_X;
      `CSU_OP_COMP_SUB: kind_next = `CSU_KIND_COMP_SUB;
      default:        known_next = 1'b0;
    endcase
  end

  csu_sub_core u_core (
    .minuend         (d_reg),
    .subtrahend      (s_reg),
    .borrow_in       ((kind_reg == `CSU_KIND_SCOMP_X) & c_reg),
    .difference      (diff),
    .unsigned_borrow (ubor),
    .signed_less     (slt),
    .equal           (eq)
  );

  // For compare-and-subtract a clear result-write bit is the suppress effect.
  assign suppress_result_effect = ~wr_reg;

  always @*
  begin
    zero_next  = eq;
    carry_next = ubor;
    res_next   = diff;
    wb_next    = wr_reg;
    case (kind_reg)
      `CSU_KIND_UCOMP:
      begin
        zero_next  = eq;
        carry_next = ubor;
      end
      `CSU_KIND_SCOMP:
      begin
        zero_next  = eq;
        carry_next = slt;
      end
      `CSU_KIND_SCOMP_X:
      begin
        zero_next  = z_reg & eq;
        carry_next = slt;
      end
      `CSU_KIND_COMP_SUB:
      begin
        zero_next  = eq;
        carry_next = ~ubor;
        res_next   = ubor ? d_reg : diff;
        wb_next    = ~suppress_result_effect;
      end
      default: zero_next = eq;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      busy_reg       <= 1'b0;
      cnt_reg        <= 3'h0;
      kind_reg       <= `CSU_KIND_UCOMP;
      exec_reg       <= 1'b0;
      unsup_reg      <= 1'b0;
      zero_wen_reg   <= 1'b0;
      carry_wen_reg  <= 1'b0;
      wr_reg         <= 1'b0;
      d_reg          <= 32'h00000000;
      s_reg          <= 32'h00000000;
      z_reg          <= 1'b0;
      c_reg          <= 1'b0;
      done           <= 1'b0;
      zero_out       <= 1'b0;
      carry_out      <= 1'b0;
      wb_en          <= 1'b0;
      wb_data        <= 32'h00000000;
      last_unsup_reg <= 1'b0;
      last_skip_reg  <= 1'b0;
      result_reg     <= 32'h00000000;
      count_reg      <= 32'h00000000;
      lastop_reg     <= 6'h00;
    end
    else
    begin
      done  <= 1'b0;
      wb_en <= 1'b0;
      if (take)
      begin
        busy_reg   <= 1'b1;
        cnt_reg    <= 3'h0;
        kind_reg   <= kind_next;
        unsup_reg  <= ~known_next;
        exec_reg   <= known_next & cond_met(cond_field, carry_in, zero_in);
        zero_wen_reg  <= write_equal_flag_effect;
        carry_wen_reg <= write_borrow_flag_effect;
        wr_reg     <= write_result_effect;
        d_reg      <= dest_value;
        s_reg      <= second_operand;
        z_reg      <= zero_in;
        c_reg      <= carry_in;
        lastop_reg <= instr_code;
      end
      else if (busy_reg)
      begin
        cnt_reg <= cnt_reg + 3'h1;
      end
      if (commit)
      begin
        busy_reg       <= 1'b0;
        done           <= 1'b1;
        last_unsup_reg <= unsup_reg;
        last_skip_reg  <= ~unsup_reg & ~exec_reg;
        zero_out       <= (exec_reg & zero_wen_reg) ? zero_next : z_reg;
        carry_out      <= (exec_reg & carry_wen_reg) ? carry_next : c_reg;
        wb_en          <= exec_reg & wb_next;
        wb_data        <= res_next;
        if (exec_reg)
        begin
          result_reg <= res_next;
          count_reg  <= count_reg + 32'h00000001;
        end
      end
    end
  end

  // Write channel: address and data are taken together when both are offered and no write response is pending.
  assign wr_take       = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      ctrl_reg     <= `CSU_CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CSU_RESP_OKAY;
    end
    else
    begin
      if (wr_take)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_mapped(s_axi_awaddr) ? `CSU_RESP_OKAY : `CSU_RESP_SLVERR;
        if ((s_axi_awaddr == `CSU_REG_CTRL) && s_axi_wstrb[0])
        begin
          ctrl_reg <= {31'h00000000, s_axi_wdata[`CSU_CTRL_ENABLE]};
        end
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @*
  begin
    rdata_next = 32'h00000000;
    case (s_axi_araddr)
      `CSU_REG_CTRL:   rdata_next = ctrl_reg;
      `CSU_REG_STATUS: rdata_next = {29'h0000000, last_skip_reg, last_unsup_reg, busy_reg};
      `CSU_REG_RESULT: rdata_next = result_reg;
      `CSU_REG_COUNT:  rdata_next = count_reg;
      `CSU_REG_FLAGS:  rdata_next = {30'h0000000, carry_out, zero_out};
      `CSU_REG_LASTOP: rdata_next = {26'h0000000, lastop_reg};
      default:         rdata_next = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `CSU_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && !s_axi_rvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdata_next;
        s_axi_rresp  <= reg_mapped(s_axi_araddr) ? `CSU_RESP_OKAY : `CSU_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ---- logic/csu_defs.vh ----
// Purpose: Constants of the compare and subtract unit.
// Assumes: Included by the unit's top design file only; the sub core does not include it.
// Notes:   Definitions only.
`ifndef CSU_DEFS_VH
`define CSU_DEFS_VH

`define CSU_OP_UCOMP      6'h21
`define CSU_OP_SCOMP      6'h30
`define CSU_OP_SCOMP_X    6'h31
`define CSU_OP_COMP_SUB   6'h38
`define CSU_COND_ALWAYS   4'hF

`define CSU_KIND_UCOMP    2'h0
`define CSU_KIND_SCOMP    2'h1
`define CSU_KIND_SCOMP_X  2'h2
`define CSU_KIND_COMP_SUB 2'h3

`define CSU_SLOT_CLOCKS   3'h4
`define CSU_IMM_WIDTH     9
`define CSU_IMM_PAD       23'h000000

`define CSU_ADDR_WIDTH    5
`define CSU_REG_CTRL      5'h00
`define CSU_REG_STATUS    5'h04
`define CSU_REG_RESULT    5'h08
`define CSU_REG_COUNT     5'h0C
`define CSU_REG_FLAGS     5'h10
`define CSU_REG_LASTOP    5'h14

`define CSU_CTRL_ENABLE   0
`define CSU_CTRL_RESET    32'h00000001
`define CSU_STAT_BUSY     0
`define CSU_STAT_UNSUP    1
`define CSU_STAT_SKIP     2
`define CSU_FLAG_ZERO     0
`define CSU_FLAG_CARRY    1

`define CSU_RESP_OKAY     2'h0
`define CSU_RESP_SLVERR   2'h2

`endif

// ---- logic/csu_sub_core.v ----
// Purpose: One 33-bit subtraction with unsigned and signed ordering outputs.
// Assumes: Purely combinational; operands come from registers of the caller.
// Notes:   Signed ordering comes from sign and overflow, so it holds on overflow.
`timescale 1ns/10ps
`default_nettype none

module csu_sub_core (
  input  wire [31:0] minuend,
  input  wire [31:0] subtrahend,
  input  wire        borrow_in,
  output wire [31:0] difference,
  output wire        unsigned_borrow,
  output wire        signed_less,
  output wire        equal
);

  wire [32:0] wide;
  wire        overflow;

  assign wide            = {1'b0, minuend} - {1'b0, subtrahend} - {32'h00000000, borrow_in};
  assign difference      = wide[31:0];
  assign unsigned_borrow = wide[32];
  assign overflow        = (minuend[31] ^ subtrahend[31]) & (minuend[31] ^ wide[31]);
  assign signed_less     = wide[31] ^ overflow;
  assign equal           = (wide[31:0] == 32'h00000000);

endmodule

`default_nettype wire

// ---- dv/csu_decoder_model.sv ----
// Purpose: Issuing-side flag store that feeds the unit's flags back in.
// Assumes: Flags are captured at each commit pulse.
// Notes:   Lets instructions chain as a multi-word compare would.
`timescale 1ns/10ps
`default_nettype none

module csu_decoder_model (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic done,
  input  wire logic zero_out,
  input  wire logic carry_out,
  output logic      zero_in,
  output logic      carry_in
);
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      zero_in <= 1'b0;
      carry_in <= 1'b0;
    end
    else if (done)
    begin
      zero_in <= zero_out;
      carry_in <= carry_out;
    end
  end
endmodule

`default_nettype wire

// ---- dv/csu_compare_subtract_unit_asserts.sv ----
// Purpose: Slot timing and result properties of the unit.
// Assumes: Bound to the unit; watches its instruction side.
// Notes:   One clock domain, so default clocking and disable are used.
`timescale 1ns/10ps
`default_nettype none

module csu_cmp_sub_asserts #(
  parameter [2:0] SLOT_CLOCKS = 3'h4
) (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        issue_valid,
  input wire logic        issue_ready,
  input wire logic [5:0]  instr_code,
  input wire logic        write_equal_flag_effect,
  input wire logic        write_borrow_flag_effect,
  input wire logic        write_result_effect,
  input wire logic        imm_effect,
  input wire logic [3:0]  cond_field,
  input wire logic [31:0] dest_value,
  input wire logic [31:0] src_value,
  input wire logic        zero_in,
  input wire logic        done,
  input wire logic        zero_out,
  input wire logic        carry_out,
  input wire logic        wb_en,
  input wire logic [31:0] wb_data
);
  wire take = issue_valid & issue_ready;
  wire go   = take & (cond_field == 4'hF) & ~imm_effect;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  property p_busy;
    take |=> !issue_ready [*3];
  endproperty
  a_busy: assert property (p_busy) else $error("ready inside slot");
  property p_done;
    take |-> ##4 done;
  endproperty
  a_done: assert property (p_done) else $error("no commit after slot");
  property p_wbdone;
    wb_en |-> done;
  endproperty
  a_wbdone: assert property (p_wbdone) else $error("write-back off commit");
  property p_hold;
    !done |-> $stable(zero_out) && $stable(carry_out) && $stable(wb_data);
  endproperty
  a_hold: assert property (p_hold) else $error("outputs moved");
  property p_keepz;
    take && !write_equal_flag_effect |-> ##4 zero_out == $past(zero_in, 4);
  endproperty
  a_keepz: assert property (p_keepz) else $error("zero changed");
  property p_ueq;
    go && instr_code == 6'h21 && write_equal_flag_effect
      |-> ##4 zero_out == ($past(dest_value, 4) == $past(src_value, 4));
  endproperty
  a_ueq: assert property (p_ueq) else $error("bad equal flag");
  property p_slt;
    go && instr_code == 6'h30 && write_borrow_flag_effect
      |-> ##4 carry_out == ($signed($past(dest_value, 4)) < $signed($past(src_value, 4)));
  endproperty
  a_slt: assert property (p_slt) else $error("bad signed borrow");
  property p_subc;
    go && instr_code == 6'h38 && write_borrow_flag_effect
      |-> ##4 carry_out == ($past(dest_value, 4) >= $past(src_value, 4));
  endproperty
  a_subc: assert property (p_subc) else $error("bad subtract carry");
  property p_subd;
    go && instr_code == 6'h38 && write_result_effect |-> ##4 wb_en && wb_data ==
      (($past(dest_value, 4) >= $past(src_value, 4)) ?
      $past(dest_value, 4) - $past(src_value, 4) : $past(dest_value, 4));
  endproperty
  a_subd: assert property (p_subd) else $error("bad subtract result");
  property p_nowb;
    go && instr_code == 6'h38 && !write_result_effect |-> ##4 !wb_en;
  endproperty
  a_nowb: assert property (p_nowb) else $error("suppressed write seen");
endmodule

bind csu_compare_subtract_unit csu_cmp_sub_asserts #(.SLOT_CLOCKS(SLOT_CLOCKS))
  i_csu_cmp_sub_asserts (.ref_clk(ref_clk), .nrst(nrst), .issue_valid(issue_valid),
    .issue_ready(issue_ready), .instr_code(instr_code),
    .write_equal_flag_effect(write_equal_flag_effect),
    .write_borrow_flag_effect(write_borrow_flag_effect),
    .write_result_effect(write_result_effect), .imm_effect(imm_effect),
    .cond_field(cond_field), .dest_value(dest_value), .src_value(src_value),
    .zero_in(zero_in), .done(done), .zero_out(zero_out), .carry_out(carry_out),
    .wb_en(wb_en), .wb_data(wb_data));

`default_nettype wire

// ---- dv/csu_compare_subtract_unit_tb_top.sv ----
// Purpose: Self-checking bench of the compare and subtract unit.
// Assumes: Flags return through the decoder model between instructions.
// Notes:   Expected values are worked out by hand.
`timescale 1ns/10ps
`default_nettype none

module csu_compare_subtract_unit_tb_top;
  logic        ref_clk, nrst, issue_valid, issue_ready, done, zero_out, carry_out, wb_en;
  logic        write_equal_flag_effect, write_borrow_flag_effect, write_result_effect;
  logic        imm_effect, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  cond_field, s_axi_wstrb;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [5:0]  instr_code;
  logic [8:0]  imm_literal;
  logic [31:0] dest_value, src_value, wb_data, s_axi_wdata, s_axi_rdata;
  wire         zero_in, carry_in;
  integer      n_fail, comparisons;

  csu_compare_subtract_unit #(.SLOT_CLOCKS(3'h4)) i_csu_compare_subtract_unit (
    .ref_clk(ref_clk), .nrst(nrst), .issue_valid(issue_valid), .issue_ready(issue_ready),
    .instr_code(instr_code), .write_equal_flag_effect(write_equal_flag_effect),
    .write_borrow_flag_effect(write_borrow_flag_effect),
    .write_result_effect(write_result_effect), .imm_effect(imm_effect),
    .cond_field(cond_field), .dest_value(dest_value), .src_value(src_value),
    .imm_literal(imm_literal), .zero_in(zero_in), .carry_in(carry_in), .done(done),
    .zero_out(zero_out), .carry_out(carry_out), .wb_en(wb_en), .wb_data(wb_data),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  csu_decoder_model i_csu_decoder_model (.ref_clk(ref_clk), .nrst(nrst), .done(done),
    .zero_out(zero_out), .carry_out(carry_out), .zero_in(zero_in), .carry_in(carry_in));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task close_out;
  begin
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask

  task check(input [31:0] got, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask

  task hang(input integer n);
  begin
    if (n >= 20)
    begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: wait ran out", $time);
      close_out;
    end
  end
  endtask

  // Effects e are write-zero, write-carry, write-result, immediate; ex is zero, carry, wb_en.
  task automatic op(input [5:0] c, input [3:0] e, input [3:0] cf, input [31:0] d,
                    input [31:0] s, input [2:0] ex, input [31:0] wd);
    integer n;
    begin
      @(posedge ref_clk);
      issue_valid <= 1'b1;
      instr_code <= c;
      {write_equal_flag_effect, write_borrow_flag_effect, write_result_effect, imm_effect} <= e;
      cond_field <= cf;
      dest_value <= d;
      src_value <= e[0] ? ~s : s;
      imm_literal <= s[8:0];
      @(negedge ref_clk);
      for (n = 0; n < 20 && issue_ready !== 1'b1; n = n + 1) @(negedge ref_clk);
      hang(n);
      @(posedge ref_clk);
      issue_valid <= 1'b0;
      @(negedge ref_clk);
      for (n = 0; n < 20 && done !== 1'b1; n = n + 1) @(negedge ref_clk);
      hang(n);
      check(n, 32'h3);
      check({29'h0, zero_out, carry_out, wb_en}, {29'h0, ex});
      if (ex[0])
        check(wb_data, wd);
    end
  endtask

  task automatic axi_wr(input [4:0] a, input [31:0] dt, input [1:0] er);
    integer n;
    begin
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dt;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(negedge ref_clk);
      for (n = 0; n < 20 && s_axi_awready !== 1'b1; n = n + 1) @(negedge ref_clk);
      hang(n);
      @(posedge ref_clk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      @(negedge ref_clk);
      for (n = 0; n < 20 && s_axi_bvalid !== 1'b1; n = n + 1) @(negedge ref_clk);
      hang(n);
      check({30'h0, s_axi_bresp}, {30'h0, er});
      @(posedge ref_clk);
      s_axi_bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input [4:0] a, input [31:0] ed, input [1:0] er);
    integer n;
    begin
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(negedge ref_clk);
      for (n = 0; n < 20 && s_axi_arready !== 1'b1; n = n + 1) @(negedge ref_clk);
      hang(n);
      @(posedge ref_clk);
      s_axi_arvalid <= 1'b0;
      @(negedge ref_clk);
      for (n = 0; n < 20 && s_axi_rvalid !== 1'b1; n = n + 1) @(negedge ref_clk);
      hang(n);
      check(s_axi_rdata, ed);
      check({30'h0, s_axi_rresp}, {30'h0, er});
      @(posedge ref_clk);
      s_axi_rready <= 1'b0;
    end
  endtask

  task t_cmp;
  begin
    op(6'h21, 4'hC, 4'hF, 32'h3, 32'h3, 3'h4, 32'h0);
    op(6'h21, 4'hE, 4'hF, 32'h7FFFFFFF, 32'h80000000, 3'h3, 32'hFFFFFFFF);
    op(6'h21, 4'hD, 4'hF, 32'h1FF, 32'h1FF, 3'h4, 32'h0);
  end
  endtask

  task t_compare_signed;
  begin
    op(6'h30, 4'h4, 4'hF, 32'h80000000, 32'h7FFFFFFF, 3'h6, 32'h0);
    op(6'h30, 4'hE, 4'hF, 32'h80000000, 32'h1, 3'h3, 32'h7FFFFFFF);
    op(6'h30, 4'hE, 4'hF, 32'h7FFFFFFF, 32'hFFFFFFFF, 3'h1, 32'h80000000);
  end
  endtask

  task t_compare_and_subtract;
  begin
    op(6'h38, 4'hE, 4'hF, 32'h3, 32'h4, 3'h1, 32'h3);
    op(6'h38, 4'hC, 4'hF, 32'h3, 32'h2, 3'h2, 32'h0);
    op(6'h38, 4'h3, 4'hF, 32'h5, 32'h2, 3'h3, 32'h3);
    op(6'h38, 4'hE, 4'hF, 32'h3, 32'h3, 3'h7, 32'h0);
  end
  endtask

  task t_cmpsx;
  begin
    op(6'h31, 4'hC, 4'hF, 32'h3, 32'h2, 3'h4, 32'h0);
    op(6'h31, 4'hC, 4'hF, 32'h3, 32'h3, 3'h4, 32'h0);
    op(6'h31, 4'hE, 4'hF, 32'hFFFFFFFE, 32'hFFFFFFFF, 3'h3, 32'hFFFFFFFF);
    op(6'h31, 4'hE, 4'hF, 32'hFFFFFFFE, 32'hFFFFFFFE, 3'h3, 32'hFFFFFFFF);
    op(6'h21, 4'hC, 4'hF, 32'hFFFFFFFF, 32'h1, 3'h0, 32'h0);
    op(6'h31, 4'hC, 4'hF, 32'hFFFFFFFF, 32'h0, 3'h2, 32'h0);
    op(6'h21, 4'hC, 4'h0, 32'h1, 32'h1, 3'h2, 32'h0);
  end
  endtask

  task t_regs;
  begin
    axi_rd(5'h10, 32'h2, 2'h0);
    axi_rd(5'h0C, 32'h10, 2'h0);
    axi_rd(5'h04, 32'h4, 2'h0);
    axi_rd(5'h08, 32'hFFFFFFFF, 2'h0);
    axi_rd(5'h14, 32'h21, 2'h0);
    axi_rd(5'h00, 32'h1, 2'h0);
    axi_wr(5'h00, 32'h0, 2'h0);
    @(negedge ref_clk);
    check({31'h0, issue_ready}, 32'h0);
    axi_wr(5'h00, 32'h1, 2'h0);
    axi_rd(5'h18, 32'h0, 2'h2);
    axi_wr(5'h18, 32'h5, 2'h2);
    op(6'h3F, 4'hE, 4'hF, 32'h1, 32'h1, 3'h2, 32'h0);
    axi_rd(5'h04, 32'h2, 2'h0);
    axi_rd(5'h0C, 32'h10, 2'h0);
  end
  endtask

  initial
  begin
    n_fail = 0;
    comparisons = 0;
    {nrst, issue_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, imm_effect, write_result_effect} = 4'h0;
    {write_equal_flag_effect, write_borrow_flag_effect} = 2'h0;
    {instr_code, cond_field, imm_literal} = 19'h00000;
    {dest_value, src_value, s_axi_wdata} = 96'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 14'h000F;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    t_cmp;
    t_compare_signed;
    t_compare_and_subtract;
    t_cmpsx;
    t_regs;
    close_out;
  end
endmodule

`default_nettype wire
